/* File: rtl/opm_ctrl.sv */
// oscillator_power_mode_control top: registers, stable flags, clock mux
// select, halt state machine and wake-up; oscillators are modelled by
// start-up counters, the divided clock is signalled as a log2 divide code
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module opm_ctrl #(
	parameter int START_CYC = opm_pkg::OPM_START_CYC,
	parameter int PORT_W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// cpu events
	input wire logic halt_instr,
	input wire logic clear_watchdog_instr,
	input wire logic irq_request,
	input wire logic irq_pending_at_halt,
	input wire logic irq_serviceable,
	input wire logic wdt_enabled,
	input wire logic wdt_overflow,
	input wire logic int_rc_stable,
	input wire logic [PORT_W-1:0] port_a_pins,
	input wire logic [PORT_W-1:0] port_a_wake_mask,
	// clock controls
	output logic hs_crystal_run,
	output logic hs_crystal_high_drive,
	output logic ls_crystal_run,
	output logic slow_rc_run,
	output logic high_clk_on,
	output logic sub_clk_on,
	output logic sys_clk_on,
	output logic sys_on_sub,
	output logic [2:0] sys_div_log2,
	// cpu controls
	output logic cpu_hold,
	output logic wdt_clear,
	output logic pc_sp_reset,
	output logic resume_next,
	output logic irq_enter,
	output logic power_down_flag,
	output logic time_out_flag
);
	import opm_pkg::*;

	initial begin
		if (START_CYC < 1 || PORT_W < 1) $error("opm_ctrl: bad parameter");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [2:0] sysclk_select; // requested select code
	logic high_clock_source_sel;
	logic low_clock_source_sel;
	logic high_osc_keep_on_halt;
	logic sub_osc_keep_on_halt;
	logic hs_crystal_range_sel;
	logic hs_crystal_enable;
	logic ls_crystal_enable;
	logic hs_crystal_stable_flag;
	logic ls_crystal_stable_flag;
	logic [31:0] hs_cnt; // start-up timers
	logic [31:0] ls_cnt;
	logic on_sub; // clock actually on sub
	opm_state_t state;
	logic [PORT_W-1:0] port_prev;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_scc = reg_write && reg_addr == OPM_SCC_ADDR;
	wire wr_high_speed_crystal_control = reg_write && reg_addr == OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR;
	wire wr_low_speed_crystal_control = reg_write && reg_addr == OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR;
	wire hs_rise = wr_high_speed_crystal_control && reg_wdata[OPM_EN_BIT] && !hs_crystal_enable;
	wire ls_rise = wr_low_speed_crystal_control && reg_wdata[OPM_EN_BIT] && !ls_crystal_enable;
	wire halted = state != OPM_RUN;
	// sub source readiness
	wire sub_ready = low_clock_source_sel ? ls_crystal_stable_flag : 1'b1;
	// fast source readiness
	wire high_ready = high_clock_source_sel ? hs_crystal_stable_flag : int_rc_stable;
	wire want_sub = sysclk_select == OPM_SEL_SUB;
	// pin edge falling and enabled
	wire pin_wake = |(port_prev & ~port_a_pins & port_a_wake_mask);
	// pending-before-halt interrupt cannot wake
	wire irq_wake = irq_request && !irq_pending_at_halt;
	wire wake = halted && (pin_wake || irq_wake || wdt_overflow);

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sysclk_select <= OPM_SEL_RESET;
			high_clock_source_sel <= 1'b0;
			low_clock_source_sel <= 1'b0;
			high_osc_keep_on_halt <= 1'b0;
			sub_osc_keep_on_halt <= 1'b0;
			hs_crystal_range_sel <= 1'b0;
			hs_crystal_enable <= 1'b0;
			ls_crystal_enable <= 1'b0;
		end else begin
			if (wr_scc) begin
				sysclk_select <= reg_wdata[OPM_SEL_LSB +: 3];
				high_clock_source_sel <= reg_wdata[OPM_FHS_BIT];
				low_clock_source_sel <= reg_wdata[OPM_FSS_BIT];
				high_osc_keep_on_halt <= reg_wdata[OPM_HKEEP_BIT];
				sub_osc_keep_on_halt <= reg_wdata[OPM_SKEEP_BIT];
			end
			if (wr_high_speed_crystal_control) begin
				// range is frozen while enabled; software should not try
				if (!hs_crystal_enable)
					hs_crystal_range_sel <= reg_wdata[OPM_RANGE_BIT];
				hs_crystal_enable <= reg_wdata[OPM_EN_BIT];
			end
			if (wr_low_speed_crystal_control)
				ls_crystal_enable <= reg_wdata[OPM_EN_BIT];
		end
	end

	// ----------------------------------------
	// oscillator start-up and stable flags
	// ----------------------------------------
	// flag drops on enable and rises after the start-up count
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hs_cnt <= '0;
			ls_cnt <= '0;
			hs_crystal_stable_flag <= 1'b0;
			ls_crystal_stable_flag <= 1'b0;
		end else begin
			if (hs_rise || !hs_crystal_run) begin
				hs_cnt <= '0;
				hs_crystal_stable_flag <= 1'b0;
			end else if (hs_cnt >= 32'(START_CYC - 1)) begin
				hs_crystal_stable_flag <= 1'b1;
			end else begin
				hs_cnt <= hs_cnt + 32'd1;
			end
			if (ls_rise || !ls_crystal_run) begin
				ls_cnt <= '0;
				ls_crystal_stable_flag <= 1'b0;
			end else if (ls_cnt >= 32'(START_CYC - 1)) begin
				ls_crystal_stable_flag <= 1'b1;
			end else begin
				ls_cnt <= ls_cnt + 32'd1;
			end
		end
	end

	// ----------------------------------------
	// clock source switch
	// ----------------------------------------
	// switch only once the target source is stable
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			on_sub <= 1'b0;
			sys_div_log2 <= 3'h0;
		end else if (want_sub && sub_ready) begin
			on_sub <= 1'b1;
		end else if (!want_sub && high_ready) begin
			on_sub <= 1'b0;
			sys_div_log2 <= sysclk_select;
		end
	end

	// ----------------------------------------
	// halt and wake state machine
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= OPM_RUN;
			port_prev <= '0;
			power_down_flag <= 1'b0;
			time_out_flag <= 1'b0;
			wdt_clear <= 1'b0;
			pc_sp_reset <= 1'b0;
			resume_next <= 1'b0;
			irq_enter <= 1'b0;
		end else begin
			port_prev <= port_a_pins;
			wdt_clear <= 1'b0;
			pc_sp_reset <= 1'b0;
			resume_next <= 1'b0;
			irq_enter <= 1'b0;
			if (clear_watchdog_instr && !halted) begin
				power_down_flag <= 1'b0;
				wdt_clear <= 1'b1;
			end
			if (state == OPM_RUN && halt_instr) begin
				power_down_flag <= 1'b1;
				time_out_flag <= 1'b0;
				wdt_clear <= 1'b1;
				case ({high_osc_keep_on_halt, sub_osc_keep_on_halt})
					2'b00: state <= OPM_SLEEP;
					2'b01: state <= OPM_IDLE_LOW;
					2'b11: state <= OPM_IDLE_BOTH;
					default: state <= OPM_IDLE_HIGH;
				endcase
			end else if (wake) begin
				state <= OPM_RUN;
				if (wdt_overflow) begin
					time_out_flag <= 1'b1;
					pc_sp_reset <= 1'b1;
				end else if (irq_wake && irq_serviceable && !pin_wake) begin
					irq_enter <= 1'b1;
				end else begin
					resume_next <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// clock gating outputs
	// ----------------------------------------
	// watchdog overrules a cleared keep bit for the slow rc
	wire keep_sub = state == OPM_IDLE_LOW || state == OPM_IDLE_BOTH;
	wire keep_high = state == OPM_IDLE_HIGH || state == OPM_IDLE_BOTH;
	assign high_clk_on = halted ? keep_high : 1'b1;
	assign sub_clk_on = halted ? keep_sub : 1'b1;
	assign sys_on_sub = on_sub;
	// system clock follows its source; sleep stops it
	assign sys_clk_on = on_sub ? sub_clk_on : high_clk_on;
	// held cpu keeps all state frozen
	assign cpu_hold = halted;
	assign hs_crystal_run = hs_crystal_enable;
	assign ls_crystal_run = ls_crystal_enable;
	assign hs_crystal_high_drive = hs_crystal_range_sel;
	assign slow_rc_run = !halted || keep_sub || wdt_enabled;

	// ----------------------------------------
	// read port
	// ----------------------------------------
	wire [7:0] scc_val = {sysclk_select, 1'b0, high_clock_source_sel,
		low_clock_source_sel, high_osc_keep_on_halt, sub_osc_keep_on_halt};
	wire [7:0] high_speed_crystal_control_val = {5'h00, hs_crystal_range_sel, hs_crystal_stable_flag,
		hs_crystal_enable};
	wire [7:0] low_speed_crystal_control_val = {6'h00, ls_crystal_stable_flag, ls_crystal_enable};
	// fast rc flag passes straight through
	wire [7:0] stat_val = {3'h0, int_rc_stable, on_sub, halted, time_out_flag,
		power_down_flag};
	wire [7:0] rd_mux = reg_addr == OPM_SCC_ADDR ? scc_val :
		reg_addr == OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR ? high_speed_crystal_control_val :
		reg_addr == OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR ? low_speed_crystal_control_val :
		reg_addr == OPM_STAT_ADDR ? stat_val : 8'h00;

	// data one cycle after the read strobe, zero otherwise
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			reg_rdata <= OPM_REG_RESET;
		else
			reg_rdata <= reg_read ? rd_mux : 8'h00;
	end
endmodule

/* File: rtl/opm_pkg.sv */
// oscillator and power-mode control: register map, fields, timing counts
// assumes a byte-wide register port and one 200 MHz system clock
// Behaviour
// - range bit picks low or high drive
// - fast crystal enable clears, later sets stable
// - enable bits run oscillators, reset to zero
// - slow crystal enable clears, later sets stable
// - select 111 moves system clock to sub
// - sub source chosen, switch waits stable
// - select 000-110 gives fast clock divided
// - return to fast waits for restart
// - halt picks state from keep bits
// - sleep stops system clock, holds cpu
// - low idle stops fast, keeps sub
// - both idle keeps both clocks running
// - high idle keeps fast, stops sub
// - low power states freeze cpu state
// - halt sets power-down, clears time-out
// - halt clears the watchdog counter
// - wake on port edge, interrupt, watchdog
// - power-up or clear watchdog clears power-down
// - watchdog wake sets time-out, resets pc/sp
// - pin or unserviceable interrupt resumes after halt
// - interrupt pending before halt cannot wake
// - select field decode, resets to 000
// - source select bits pick rc or crystal
// - watchdog keeps slow rc during halt
// - fast rc flag reads its stability
package opm_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OPM_SCC_ADDR = 8'h00; // system clock control
	localparam logic [7:0] OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR = 8'h01; // high_speed_crystal_control
	localparam logic [7:0] OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR = 8'h02; // low_speed_crystal_control
	localparam logic [7:0] OPM_STAT_ADDR = 8'h03; // status flags and clock state
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int OPM_SEL_LSB = 5; // sysclk_select bits 7..5
	localparam int OPM_FHS_BIT = 3;
	localparam int OPM_FSS_BIT = 2;
	localparam int OPM_HKEEP_BIT = 1;
	localparam int OPM_SKEEP_BIT = 0;
	localparam int OPM_RANGE_BIT = 2;
	localparam int OPM_FLAG_BIT = 1;
	localparam int OPM_EN_BIT = 0;
	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [2:0] OPM_SEL_SUB = 3'h7; // sub clock code
	localparam logic [2:0] OPM_SEL_RESET = 3'h0;
	localparam logic [7:0] OPM_REG_RESET = 8'h00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int OPM_CLK_MHZ = 200;
	localparam int OPM_START_US = 10; // modelled oscillator start-up
	localparam int OPM_START_CYC = OPM_START_US * OPM_CLK_MHZ;
	typedef enum logic [2:0] {
		OPM_RUN, OPM_SLEEP, OPM_IDLE_LOW, OPM_IDLE_BOTH, OPM_IDLE_HIGH
	} opm_state_t;
endpackage

/* File: sim/opm_ctrl_checker.sv */
// opm_ctrl_checker: temporal checks on halt, wake-up and clock outputs
// assumes one clock domain, async active-high reset, bound to opm_ctrl
`timescale 1ns/100ps
module opm_ctrl_checker #(
	parameter int PORT_W = 8
) (
	// clock, reset and cpu events
	input wire logic sys_clk, reset, halt_instr, clear_watchdog_instr,
	input wire logic irq_request, irq_pending_at_halt, irq_serviceable,
	input wire logic wdt_enabled, wdt_overflow,
	input wire logic [PORT_W-1:0] port_a_pins, port_a_wake_mask,
	// clock and cpu controls
	input wire logic slow_rc_run, high_clk_on, sub_clk_on, sys_clk_on, cpu_hold,
	input wire logic wdt_clear, pc_sp_reset, resume_next, irq_enter,
	input wire logic power_down_flag, time_out_flag
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [PORT_W-1:0] prev_pins; // last pin levels, for falling edges
	// released pins idle high, so reset to ones to avoid a false edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) prev_pins <= '1;
		else prev_pins <= port_a_pins;
	end
	wire pin_edge = |(prev_pins & ~port_a_pins & port_a_wake_mask);
	wire irq_wake = irq_request && !irq_pending_at_halt; // stale request cannot wake
	sequence s_halt;
		halt_instr && !cpu_hold;
	endsequence
	sequence s_asleep;
		cpu_hold && !wdt_overflow;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	halt_flags_a: assert property (s_halt |=> power_down_flag && !time_out_flag && wdt_clear)
		else $error("halt did not set flags or clear watchdog");
	sleep_stops_a: assert property (cpu_hold && !high_clk_on && !sub_clk_on |-> !sys_clk_on)
		else $error("system clock runs in sleep");
	slow_rc_keep_a: assert property (cpu_hold && wdt_enabled |-> slow_rc_run)
		else $error("slow rc stopped with watchdog on");
	wdt_wake_a: assert property (cpu_hold ##0 wdt_overflow |=> !cpu_hold && pc_sp_reset && time_out_flag)
		else $error("watchdog wake wrong");
	pin_wake_a: assert property (s_asleep ##0 (pin_edge && !irq_wake) |=> !cpu_hold && resume_next && !irq_enter)
		else $error("pin wake wrong");
	irq_wake_a: assert property (s_asleep ##0 (irq_wake && irq_serviceable && !pin_edge) |=> !cpu_hold && irq_enter)
		else $error("interrupt wake wrong");
	stay_held_a: assert property (s_asleep ##0 (!pin_edge && !irq_wake) |=> cpu_hold)
		else $error("woke without a source");
	clear_pdf_a: assert property (clear_watchdog_instr && !halt_instr && !cpu_hold |=> !power_down_flag && wdt_clear)
		else $error("clear watchdog did not clear power down");
	held_flags_a: assert property (cpu_hold ##1 cpu_hold |-> $stable(power_down_flag) && $stable(time_out_flag))
		else $error("flags changed while held");
endmodule
bind opm_ctrl opm_ctrl_checker #(.PORT_W(PORT_W)) i_opm_ctrl_checker (.sys_clk, .reset, .halt_instr,
	.clear_watchdog_instr, .irq_request, .irq_pending_at_halt, .irq_serviceable, .wdt_enabled,
	.wdt_overflow, .port_a_pins, .port_a_wake_mask, .slow_rc_run, .high_clk_on, .sub_clk_on,
	.sys_clk_on, .cpu_hold, .wdt_clear, .pc_sp_reset, .resume_next, .irq_enter, .power_down_flag,
	.time_out_flag);

/* File: sim/tb_opm_ctrl.sv */
// tb_opm_ctrl: self-checking bench for registers, clock switching, halt and wake
// assumes opm_pkg and opm_ctrl compiled first, checker bound separately
`timescale 1ns/100ps
module tb_opm_ctrl;
	import opm_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int SC = 4; // shortened oscillator start-up
	logic sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, halt_instr = 0;
	logic clear_watchdog_instr = 0, irq_request = 0, irq_pending_at_halt = 0, irq_serviceable = 0;
	logic wdt_enabled = 1, wdt_overflow = 0, int_rc_stable = 1, rd_prev = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, port_a_pins = 8'hFF, port_a_wake_mask = 0;
	logic [2:0] sys_div_log2;
	logic hs_crystal_run, hs_crystal_high_drive, ls_crystal_run, slow_rc_run, high_clk_on;
	logic sub_clk_on, sys_clk_on, sys_on_sub, cpu_hold, wdt_clear, pc_sp_reset, resume_next;
	logic irq_enter, power_down_flag, time_out_flag;
	int n_errors = 0, checks_done = 0;
	integer seed = 32'h968A220E; // fixed seed for the wake masks
	logic [7:0] exp_q[$]; // expected read data, oldest first
	always #2.5 sys_clk = ~sys_clk;
	opm_ctrl #(.START_CYC(SC), .PORT_W(8)) i_opm_ctrl (.sys_clk, .reset, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .halt_instr, .clear_watchdog_instr, .irq_request,
		.irq_pending_at_halt, .irq_serviceable, .wdt_enabled, .wdt_overflow, .int_rc_stable,
		.port_a_pins, .port_a_wake_mask, .hs_crystal_run, .hs_crystal_high_drive, .ls_crystal_run,
		.slow_rc_run, .high_clk_on, .sub_clk_on, .sys_clk_on, .sys_on_sub, .sys_div_log2, .cpu_hold,
		.wdt_clear, .pc_sp_reset, .resume_next, .irq_enter, .power_down_flag, .time_out_flag);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task conclude;
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1; // let the edge's updates land
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge sys_clk);
		reg_write <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		exp_q.push_back(want);
		@(posedge sys_clk);
		reg_read <= 1'h0;
	endtask
	// bounded wait on the hold output; running out is a mismatch
	task wait_hold(input logic v);
		for (int i = 0; i < 20; i++) begin
			if (cpu_hold === v) return;
			step(1);
		end
		n_errors++;
		$display("unexpected at %0t: hold wait ran out", $time);
		conclude;
	endtask
	// ----------------------------------------
	// read monitor: data stand only in the cycle after the strobe
	// ----------------------------------------
	always @(posedge sys_clk) rd_prev <= reg_read;
	always @(negedge sys_clk) if (rd_prev) check(reg_rdata, exp_q.pop_front());
	initial begin
		#400000;
		n_errors++;
		$display("unexpected at %0t: run timed out", $time);
		conclude;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'h0;
		rd(OPM_SCC_ADDR, 8'h00);
		rd(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h00);
		rd(OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR, 8'h00);
		rd(OPM_STAT_ADDR, 8'h10);
		rd(8'h04, 8'h00); // unmapped place reads zero
		wr(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h04);
		step(1);
		check(hs_crystal_high_drive, 8'h01);
		wr(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h05);
		rd(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h05);
		step(SC + 4);
		rd(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h07);
		wr(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h01); // range change while running is dropped
		rd(OPM_HIGH_SPEED_CRYSTAL_CONTROL_ADDR, 8'h07);
		check(hs_crystal_run, 8'h01);
		wr(OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR, 8'h01);
		rd(OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR, 8'h01);
		step(SC + 4);
		rd(OPM_LOW_SPEED_CRYSTAL_CONTROL_ADDR, 8'h03);
		check(ls_crystal_run, 8'h01);
		wr(OPM_SCC_ADDR, 8'hE4); // sub clock from the slow crystal
		step(2);
		check(sys_on_sub, 8'h01);
		rd(OPM_STAT_ADDR, 8'h18);
		int_rc_stable <= 1'h0; // fast rc not yet back
		wr(OPM_SCC_ADDR, 8'h04);
		step(3);
		check(sys_on_sub, 8'h01);
		int_rc_stable <= 1'h1;
		step(2);
		check(sys_on_sub, 8'h00);
		for (int s = 0; s < 7; s++) begin
			wr(OPM_SCC_ADDR, {s[2:0], 5'h0C});
			step(2);
			check(sys_div_log2, s[2:0]);
		end
		// each keep setting, woken by pin, serviceable irq, unserviceable irq, watchdog
		for (int k = 0; k < 4; k++) begin
			port_a_wake_mask <= $random(seed) | 8'h01;
			wr(OPM_SCC_ADDR, {6'h03, k[1:0]});
			@(posedge sys_clk);
			halt_instr <= 1'h1;
			@(posedge sys_clk);
			halt_instr <= 1'h0;
			step(1);
			check(cpu_hold, 8'h01);
			check(high_clk_on, k[1]);
			check(sub_clk_on, k[0]);
			check(sys_clk_on, k[1]);
			rd(OPM_STAT_ADDR, 8'h15);
			irq_pending_at_halt <= 1'h1;
			irq_request <= 1'h1;
			step(3);
			check(cpu_hold, 8'h01);
			irq_pending_at_halt <= 1'h0;
			irq_serviceable <= k[0];
			irq_request <= (k == 1 || k == 2);
			port_a_pins <= (k == 0) ? 8'hFE : 8'hFF;
			wdt_overflow <= (k == 3);
			@(posedge sys_clk);
			irq_request <= 1'h0;
			wdt_overflow <= 1'h0;
			port_a_pins <= 8'hFF;
			wait_hold(1'h0);
			rd(OPM_STAT_ADDR, (k == 3) ? 8'h13 : 8'h11);
			@(posedge sys_clk);
			clear_watchdog_instr <= 1'h1;
			@(posedge sys_clk);
			clear_watchdog_instr <= 1'h0;
			rd(OPM_STAT_ADDR, (k == 3) ? 8'h12 : 8'h10);
		end
		step(3);
		conclude;
	end
endmodule
